/* File: pcx_crossbar.sv */
// Priority crossbar with per-pin input, output, pull-up and skip control
`timescale 1ns/1ns
module pcx_crossbar
    import pcx_pkg::*;
#(
    parameter int NPINS = DEFAULT_PINS
)
(
    input wire logic mclk,                        // System clock, 50 MHz
    input wire logic rst,                         // Synchronous reset, active high
    input wire logic [7:0] sfrAddr,               // Special register address
    input wire logic sfrWrite,                    // Write strobe
    input wire logic [7:0] sfrWdata,              // Write data
    output logic [7:0] sfrRdata,                  // Read data of the addressed register
    input wire logic crossbarGlobalEnable,        // Crossbar enable bit
    input wire logic weakPullupDisable,           // Global weak pull-up disable bit
    input wire logic [NPINS-1:0] portSkipMask,    // Per-pin skip bits
    input wire logic [NPINS-1:0] portInputMode,   // Per-pin: 1 digital, 0 analog
    input wire logic [NPINS-1:0] portOutputMode,  // Per-pin: 1 push-pull, 0 open-drain
    input wire logic [NPINS-1:0] gpioOut,         // Port latch values for plain pins
    input wire logic spiFourWire,                 // Synchronous serial uses select pin
    input wire logic [NUM_FUNC-1:0] periphOut,    // Output value of each function
    input wire logic [NUM_FUNC-1:0] periphDrive,  // Function wants to drive its pin
    output logic [NUM_FUNC-1:0] periphIn,         // Pin level seen by each function
    input wire logic [NPINS-1:0] padIn,           // Pad levels
    output logic [NPINS-1:0] padOut,              // Pad output values
    output logic [NPINS-1:0] padOeN,              // Pad output enables, low drives
    output logic [NPINS-1:0] weakPullup,          // Weak pull-up enables
    output logic [1:0] strongPullup,              // Strong pull-ups on port 2 pins 2, 3
    output logic [NPINS-1:0] portIn,              // Digital receiver output per pin
    output logic [NPINS-1:0] assignedMask         // Pins currently claimed by a function
);

    localparam int PW = $clog2(NPINS); // Width of a pin index

    // Refuse pin counts that the fixed serial pins or the index width cannot serve
    if (NPINS < MIN_PINS || NPINS > 64)
    begin : g_bad_npins
        $error("pcx_crossbar: NPINS out of range");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Routing register
    logic [7:0] routing;       // Routing select 0
    logic [7:0] next_routing;  // Value after this edge
    logic [7:0] next_rdata;    // Read data after this edge

    // Register write and read decode
    always_comb
    begin
        next_routing = routing;
        if (sfrWrite && sfrAddr == ROUTE0_ADDR)
        begin
            next_routing = sfrWdata;
        end
        next_rdata = (sfrAddr == ROUTE0_ADDR) ? routing : RDATA_RESET;
    end

    // Register storage
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            routing <= ROUTE0_RESET;
            sfrRdata <= RDATA_RESET;
        end
        else
        begin
            routing <= next_routing;
            sfrRdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Priority decode
    logic [NUM_FUNC-1:0] funcEn;        // Functions requested this cycle
    logic [NUM_FUNC-1:0] funcValid;     // Functions that hold a pin
    logic [NUM_FUNC-1:0] next_funcValid;
    logic [PW-1:0] funcPin [NUM_FUNC];  // Pin held by each function
    logic [PW-1:0] next_funcPin [NUM_FUNC];
    logic [NPINS-1:0] taken;            // Pins no longer free during the walk
    logic [NPINS-1:0] uartMask;         // Fixed serial pins
    logic [NPINS-1:0] cfgSkip;          // Skip bits the mapping was built from
    logic cfgEnable;                    // Crossbar enable the mapping was built from
    logic [NPINS-1:0] cfgInMode;        // Input modes in force

    // Requested functions from the routing bits of the next value
    always_comb
    begin
        funcEn[FN_TX] = next_routing[RB_ASYNC_SERIAL];
        funcEn[FN_RX] = next_routing[RB_ASYNC_SERIAL];
        funcEn[FN_SCK] = next_routing[RB_SYNC_SERIAL];
        funcEn[FN_MISO] = next_routing[RB_SYNC_SERIAL];
        funcEn[FN_MOSI] = next_routing[RB_SYNC_SERIAL];
        funcEn[FN_NSS] = next_routing[RB_SYNC_SERIAL] && spiFourWire;
        funcEn[FN_SDA_A] = next_routing[RB_TWOWIRE_A];
        funcEn[FN_SCL_A] = next_routing[RB_TWOWIRE_A];
        funcEn[FN_SDA_B] = next_routing[RB_TWOWIRE_B];
        funcEn[FN_SCL_B] = next_routing[RB_TWOWIRE_B];
        funcEn[FN_CMP_SYNC] = next_routing[RB_CMP_SYNC];
        funcEn[FN_CMP_ASYNC] = next_routing[RB_CMP_ASYNC];
        funcEn[FN_SYSCLK] = next_routing[RB_SYSCLK_OUT];
    end

    // Walk the functions in rank order, each after the serial lines taking the lowest free pin
    always_comb
    begin
        uartMask = '0;
        uartMask[UART_TX_PIN] = 1'b1;
        uartMask[UART_RX_PIN] = 1'b1;
        // Skipped pins start out as taken
        taken = portSkipMask;
        if (funcEn[FN_TX])
        begin
            taken = taken | uartMask;
        end
        for (int f = 0; f < NUM_FUNC; f++)
        begin
            next_funcValid[f] = 1'b0;
            next_funcPin[f] = '0;
            if (!crossbarGlobalEnable)
            begin
                // Nothing routed while the crossbar is off
                next_funcValid[f] = 1'b0;
            end
            else if (f == FN_TX || f == FN_RX)
            begin
                // Serial lines bypass the search
                next_funcValid[f] = funcEn[f];
                next_funcPin[f] = (f == FN_TX) ? PW'(UART_TX_PIN) : PW'(UART_RX_PIN);
            end
            else if (funcEn[f])
            begin
                // Downward scan leaves the lowest free pin as the choice
                for (int i = NPINS - 1; i >= 0; i--)
                begin
                    if (!taken[i])
                    begin
                        next_funcValid[f] = 1'b1;
                        next_funcPin[f] = PW'(i);
                    end
                end
                if (next_funcValid[f])
                begin
                    taken[next_funcPin[f]] = 1'b1;
                end
            end
        end
    end

    // Mapping registers, rebuilt on every edge
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            funcValid <= '0;
            cfgSkip <= '0;
            cfgEnable <= 1'b0;
            cfgInMode <= '1;
            for (int f = 0; f < NUM_FUNC; f++)
            begin
                funcPin[f] <= '0;
            end
        end
        else
        begin
            funcValid <= next_funcValid;
            cfgSkip <= portSkipMask;
            cfgEnable <= crossbarGlobalEnable;
            cfgInMode <= portInputMode;
            for (int f = 0; f < NUM_FUNC; f++)
            begin
                funcPin[f] <= next_funcPin[f];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Peripheral inputs and strong pull-ups
    logic [NUM_FUNC-1:0] next_periphIn; // Pin level each function will see
    logic [1:0] next_strong;            // Strong pull-up enables

    // Receiver of the assigned pin, idle high otherwise
    always_comb
    begin
        for (int f = 0; f < NUM_FUNC; f++)
        begin
            next_periphIn[f] = 1'b1;
            if (funcValid[f] && cfgInMode[funcPin[f]])
            begin
                next_periphIn[f] = padIn[funcPin[f]];
            end
        end
        next_strong = {2{next_routing[RB_NVM_PULLUP]}};
    end

    // Peripheral side registers
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            periphIn <= '1;
            strongPullup <= '0;
        end
        else
        begin
            periphIn <= next_periphIn;
            strongPullup <= next_strong;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-pin drivers, pull-ups and receivers
    for (genvar p = 0; p < NPINS; p++)
    begin : g_pin
        logic hit;         // Some function holds this pin
        logic [3:0] fIdx;  // Which one
        logic openDrain;   // Effective output mode
        logic val;         // Value to present
        logic drive;       // Driver on
        logic next_pull;   // Weak pull-up next

        // Output selection for one pin
        always_comb
        begin
            hit = 1'b0;
            fIdx = '0;
            for (int f = 0; f < NUM_FUNC; f++)
            begin
                if (next_funcValid[f] && next_funcPin[f] == PW'(p))
                begin
                    hit = 1'b1;
                    fIdx = 4'(f);
                end
            end
            // Two-wire pins ignore the output mode bit
            openDrain = !portOutputMode[p] || (hit && fIdx >= 4'(FN_SDA_A)
                && fIdx <= 4'(FN_SCL_B));
            val = hit ? periphOut[fIdx] : gpioOut[p];
            if (!crossbarGlobalEnable || !portInputMode[p])
            begin
                drive = 1'b0;
            end
            else if (hit)
            begin
                drive = periphDrive[fIdx] && !(openDrain && val);
            end
            else
            begin
                drive = !(openDrain && val);
            end
            next_pull = portInputMode[p] && !weakPullupDisable && openDrain
                && !(drive && !val);
        end

        // Pin registers
        always_ff @(posedge mclk)
        begin
            if (rst)
            begin
                padOut[p] <= 1'b1;
                padOeN[p] <= 1'b1;
                weakPullup[p] <= 1'b0;
                portIn[p] <= 1'b1;
                assignedMask[p] <= 1'b0;
            end
            else
            begin
                padOut[p] <= val;
                padOeN[p] <= !drive;
                weakPullup[p] <= next_pull;
                portIn[p] <= portInputMode[p] ? padIn[p] : 1'b0;
                assignedMask[p] <= hit;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    a_uart_fixed_pins: assert property (@(posedge mclk) disable iff (rst)
        funcValid[FN_TX] |-> funcPin[FN_TX] == PW'(UART_TX_PIN)
            && funcPin[FN_RX] == PW'(UART_RX_PIN))
        else $error("serial lines off their fixed pins");
    a_rank_order: assert property (@(posedge mclk) disable iff (rst)
        funcValid[FN_SCK] && funcValid[FN_MOSI] |-> funcPin[FN_MOSI] > funcPin[FN_SCK])
        else $error("lower rank took a lower pin");
    a_lowest_free: assert property (@(posedge mclk) disable iff (rst)
        funcValid[FN_SCK] && !funcValid[FN_TX]
            |-> &(cfgSkip | ~((NPINS'(1) << funcPin[FN_SCK]) - NPINS'(1))))
        else $error("first function skipped a free pin");
    a_skip_honoured: assert property (@(posedge mclk) disable iff (rst)
        funcValid[FN_SDA_A] |-> !cfgSkip[funcPin[FN_SDA_A]])
        else $error("skipped pin was assigned");
    a_xbar_off: assert property (@(posedge mclk) disable iff (rst)
        !cfgEnable |-> &padOeN && funcValid == '0)
        else $error("driver or route active with crossbar off");
    a_analog_quiet: assert property (@(posedge mclk) disable iff (rst)
        &(padOeN | cfgInMode) && (weakPullup & ~cfgInMode) == '0
            && (portIn & ~cfgInMode) == '0)
        else $error("analog pin not quiet");
    a_twowire_od: assert property (@(posedge mclk) disable iff (rst)
        funcValid[FN_SCL_A] |-> padOeN[funcPin[FN_SCL_A]] || !padOut[funcPin[FN_SCL_A]])
        else $error("two-wire pin driven high");
    a_pullup_low: assert property (@(posedge mclk) disable iff (rst)
        &(~weakPullup | padOeN | padOut))
        else $error("pull-up on while driving low");
    a_strong_pu: assert property (@(posedge mclk) disable iff (rst)
        $rose(routing[RB_NVM_PULLUP]) |-> strongPullup == 2'h3 ##1 $stable(strongPullup)
            || !routing[RB_NVM_PULLUP])
        else $error("strong pull-ups not following routing bit");
    a_route_write: assert property (@(posedge mclk) disable iff (rst)
        sfrWrite && sfrAddr == ROUTE0_ADDR && crossbarGlobalEnable
            && sfrWdata[RB_CMP_SYNC] |=> funcValid[FN_CMP_SYNC] || &(cfgSkip | assignedMask))
        else $error("mapping did not follow register write");

endmodule

/* File: pcx_crossbar_tb.sv */
// Self-checking bench for the priority crossbar and port configuration block
`timescale 1ns/1ns
module pcx_crossbar_tb
    import pcx_pkg::*;
;
    localparam int N = 24; // Pins under test
    logic mclk = 1'b0, rst = 1'b1, sfrWrite = 1'b0, crossbarGlobalEnable = 1'b0;
    logic weakPullupDisable = 1'b0, spiFourWire = 1'b0;
    logic [7:0] sfrAddr = 8'hE1, sfrWdata = 8'h00, sfrRdata;
    logic [N-1:0] portSkipMask = '0, portInputMode = '1, portOutputMode = '0, gpioOut = '0;
    logic [N-1:0] extDrive = '0, extLevel = '0, padIn, padOut, padOeN, weakPullup, portIn;
    logic [N-1:0] assignedMask;
    logic [NUM_FUNC-1:0] periphOut = '0, periphDrive = '0, periphIn;
    logic [1:0] strongPullup;
    int errors = 0, comparisons = 0, cycles = 0;
    int owner [N];                 // Function placed on each pin, -1 for none
    logic [7:0] route = 8'h00;     // Expected routing register
    logic [7:0] eRdata, eStrong;   // Expected read data and strong pull-ups
    logic [N-1:0] eAssign, eOeN, eOut, eWpu, ePortIn;
    logic eValid = 1'b0;           // Expectations exist from the first edge on
    logic [NUM_FUNC-1:0] ePeriph;  // Expected peripheral inputs
    logic [N-1:0] inModeQ = '1;    // Input modes the held mapping was built with

    always #10 mclk = ~mclk;

    pcx_crossbar #(.NPINS(N)) uut (.mclk(mclk), .rst(rst), .sfrAddr(sfrAddr),
        .sfrWrite(sfrWrite), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
        .crossbarGlobalEnable(crossbarGlobalEnable), .weakPullupDisable(weakPullupDisable),
        .portSkipMask(portSkipMask), .portInputMode(portInputMode),
        .portOutputMode(portOutputMode), .gpioOut(gpioOut), .spiFourWire(spiFourWire),
        .periphOut(periphOut), .periphDrive(periphDrive), .periphIn(periphIn), .padIn(padIn),
        .padOut(padOut), .padOeN(padOeN), .weakPullup(weakPullup),
        .strongPullup(strongPullup), .portIn(portIn), .assignedMask(assignedMask));

    pcx_pad_model #(.NPINS(N)) pads (.mclk(mclk), .padOut(padOut), .padOeN(padOeN),
        .weakPullup(weakPullup), .extDrive(extDrive), .extLevel(extLevel), .padIn(padIn));

    ////////////////////////////////////////////////////////////////////////////////
    // Random pin-wide value
    function automatic logic [N-1:0] rndPins();
        logic [31:0] w;
        w = $urandom();
        return w[N-1:0];
    endfunction

    // Whether a ranked function is asked for by the routing bits
    function automatic logic fnOn(input int f, input logic [7:0] r, input logic fw);
        case (f)
            FN_SCK, FN_MISO, FN_MOSI: return r[RB_SYNC_SERIAL];
            FN_NSS: return r[RB_SYNC_SERIAL] & fw;
            FN_SDA_A, FN_SCL_A: return r[RB_TWOWIRE_A];
            FN_SDA_B, FN_SCL_B: return r[RB_TWOWIRE_B];
            FN_CMP_SYNC: return r[RB_CMP_SYNC];
            FN_CMP_ASYNC: return r[RB_CMP_ASYNC];
            default: return r[RB_SYSCLK_OUT];
        endcase
    endfunction

    // Serial port fixed, then each function by rank takes the lowest free pin
    function automatic void mapPins(input logic [7:0] r, input logic [N-1:0] sk,
                                    input logic fw, input logic en);
        logic [N-1:0] taken;
        int p;
        taken = '0;
        for (int i = 0; i < N; i++) owner[i] = -1;
        if (!en) return;
        if (r[RB_ASYNC_SERIAL])
        begin
            owner[UART_TX_PIN] = FN_TX;
            owner[UART_RX_PIN] = FN_RX;
            taken[UART_TX_PIN] = 1'b1;
            taken[UART_RX_PIN] = 1'b1;
        end
        for (int f = FN_SCK; f < NUM_FUNC; f++)
        begin
            p = 0;
            while (p < N && (taken[p] || sk[p])) p++;
            if (fnOn(f, r, fw) && p < N)
            begin
                owner[p] = f;
                taken[p] = 1'b1;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Compare tasks, one per result width
    task automatic chkPins(input logic [N-1:0] got, input logic [N-1:0] exp, input string s);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, s, got, exp);
        end
    endtask

    task automatic chkByte(input logic [7:0] got, input logic [7:0] exp, input string s);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, s, got, exp);
        end
    endtask

    // Verdict and end of run
    task automatic end_sim();
        if (errors == 0 && comparisons > 0)
        begin
            $display("STATUS OK");
        end
        else
        begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Each edge: check last expectation, then predict from the inputs just sampled
    always @(posedge mclk)
    begin
        logic [7:0] nr;
        logic od, drv, val;
        if (eValid)
        begin
            chkPins(assignedMask, eAssign, "assigned pins");
            chkPins(padOeN, eOeN, "driver enables");
            chkPins(padOut & ~eOeN, eOut & ~eOeN, "driven values");
            chkPins(weakPullup, eWpu, "weak pull-ups");
            chkPins(portIn, ePortIn, "port inputs");
            chkByte({6'h00, strongPullup}, eStrong, "strong pull-ups");
            chkByte(sfrRdata, eRdata, "read data");
            chkPins(N'(periphIn), N'(ePeriph), "peripheral inputs");
        end
        // Peripheral inputs follow the mapping already held, one edge behind the pads
        ePeriph = '1;
        for (int i = 0; i < N; i++)
        begin
            if (!rst && owner[i] >= 0 && inModeQ[i])
            begin
                ePeriph[owner[i]] = padIn[i];
            end
        end
        nr = rst ? 8'h00 : (sfrWrite && sfrAddr == ROUTE0_ADDR) ? sfrWdata : route;
        eRdata = (!rst && sfrAddr == ROUTE0_ADDR) ? route : 8'h00;
        eStrong = {6'h00, {2{nr[RB_NVM_PULLUP]}}};
        mapPins(nr, portSkipMask, spiFourWire, crossbarGlobalEnable && !rst);
        for (int i = 0; i < N; i++)
        begin
            od = !portOutputMode[i] || (owner[i] >= FN_SDA_A && owner[i] <= FN_SCL_B);
            val = (owner[i] >= 0) ? periphOut[owner[i]] : gpioOut[i];
            drv = (owner[i] >= 0) ? periphDrive[owner[i]] : 1'b1;
            drv = drv && !(od && val) && crossbarGlobalEnable && portInputMode[i] && !rst;
            eOeN[i] = !drv;
            eOut[i] = val;
            eWpu[i] = !rst && portInputMode[i] && od && !weakPullupDisable && !(drv && !val);
            ePortIn[i] = rst ? 1'b1 : portInputMode[i] ? padIn[i] : 1'b0;
            eAssign[i] = owner[i] >= 0;
        end
        route = nr;
        inModeQ = portInputMode;
        eValid = 1'b1;
    end

    // Peripheral and board traffic changes every cycle
    always @(posedge mclk)
    begin
        periphOut <= NUM_FUNC'($urandom());
        periphDrive <= NUM_FUNC'($urandom());
        gpioOut <= rndPins();
        extDrive <= rndPins();
        extLevel <= rndPins();
    end

    // Cut a hung run short
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            errors++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register write, one-cycle strobe; address is left in place for the readback
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        sfrAddr <= a;
        sfrWrite <= 1'b1;
        sfrWdata <= d;
        @(posedge mclk);
        sfrWrite <= 1'b0;
    endtask

    // Port setup in software order: input mode, output mode, skips
    task automatic cfg(input logic [N-1:0] im, om, sk, input logic fw);
        @(posedge mclk);
        portInputMode <= im;
        @(posedge mclk);
        portOutputMode <= om;
        @(posedge mclk);
        portSkipMask <= sk | ~im;
        spiFourWire <= fw;
    endtask

    task automatic setEn(input logic v);
        @(posedge mclk);
        crossbarGlobalEnable <= v;
    endtask

    // One cycle of fully random configuration, writes possibly back to back
    task automatic randStep();
        logic [N-1:0] im;
        im = rndPins() | rndPins();
        @(posedge mclk);
        portInputMode <= im;
        portOutputMode <= rndPins();
        portSkipMask <= (rndPins() & rndPins()) | ~im;
        spiFourWire <= 1'($urandom_range(1, 0));
        weakPullupDisable <= ($urandom_range(3, 0) == 0);
        crossbarGlobalEnable <= ($urandom_range(3, 0) != 0);
        sfrWrite <= 1'($urandom_range(1, 0));
        sfrAddr <= ($urandom_range(3, 0) == 0) ? 8'($urandom()) : ROUTE0_ADDR;
        sfrWdata <= 8'($urandom());
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        void'($urandom(32'h82834152));
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        wr(ROUTE0_ADDR, 8'hFF);
        repeat (3) @(posedge mclk);
        wr(8'hE2, 8'h5A);
        repeat (2) @(posedge mclk);
        // Three-wire then four-wire synchronous serial from a clean setup
        for (int k = 0; k < 2; k++)
        begin
            setEn(1'b0);
            cfg('1, rndPins(), '0, k[0]);
            wr(ROUTE0_ADDR, 8'h02);
            setEn(1'b1);
            repeat (3) @(posedge mclk);
        end
        // Each routing bit alone, then with the serial port, over random skips
        for (int b = 0; b < 8; b++)
        begin
            cfg(rndPins() | rndPins(), rndPins(), rndPins() & rndPins(), b[0]);
            weakPullupDisable <= b[2];
            wr(ROUTE0_ADDR, 8'h01 << b);
            wr(ROUTE0_ADDR, (8'h01 << b) | 8'h01);
            repeat (2) @(posedge mclk);
        end
        // Only two free pins: late functions go unrouted
        cfg('1, '0, ~24'h000011, 1'b1);
        wr(ROUTE0_ADDR, 8'hFE);
        // Everything on, nothing skipped: full rank order
        cfg('1, rndPins(), '0, 1'b1);
        wr(ROUTE0_ADDR, 8'hFF);
        repeat (3) @(posedge mclk);
        repeat (300) randStep();
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        repeat (100) randStep();
        repeat (2) @(posedge mclk);
        end_sim();
    end
endmodule

/* File: pcx_pad_model.sv */
// Board-side model of the package pins seen by the crossbar
`timescale 1ns/1ns
module pcx_pad_model
    import pcx_pkg::*;
#(
    parameter int NPINS = DEFAULT_PINS
)
(
    input wire logic mclk,                  // System clock
    input wire logic [NPINS-1:0] padOut,    // Value the device drives
    input wire logic [NPINS-1:0] padOeN,    // Device driver enable, low drives
    input wire logic [NPINS-1:0] weakPullup, // Device weak pull-up enables
    input wire logic [NPINS-1:0] extDrive,  // Board drives the pin
    input wire logic [NPINS-1:0] extLevel,  // Level the board drives
    output logic [NPINS-1:0] padIn          // Resolved pin level
);
    ////////////////////////////////////////////////////////////////////////////////
    // A floating pin shows a level that flips every cycle, never a stale one
    logic [NPINS-1:0] floatLevel = '0;

    // Flip the floating pattern each clock
    always @(posedge mclk)
    begin
        floatLevel <= ~floatLevel;
    end

    // Device driver wins, then pull-up, then board, else floating
    always_comb
    begin
        for (int i = 0; i < NPINS; i++)
        begin
            padIn[i] = !padOeN[i] ? padOut[i] : weakPullup[i] ? 1'b1 :
                       extDrive[i] ? extLevel[i] : floatLevel[i];
        end
    end
endmodule

/* File: pcx_pkg.sv */
// Constants shared by the priority crossbar and port configuration block
package pcx_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Routing register location and reset value
    localparam logic [7:0] ROUTE0_ADDR = 8'hE1;  // Special register address of routing select 0
    localparam logic [7:0] ROUTE0_RESET = 8'h00; // All routing off after reset
    localparam logic [7:0] RDATA_RESET = 8'h00;  // Read data after reset and on other addresses

    ////////////////////////////////////////////////////////////////////////////////
    // Bit positions inside routing select 0
    localparam int RB_ASYNC_SERIAL = 0; // async_serial_route_enable
    localparam int RB_SYNC_SERIAL = 1;  // sync_serial_route_enable
    localparam int RB_TWOWIRE_A = 2;    // twowire_a_route_enable
    localparam int RB_SYSCLK_OUT = 3;   // sysclk_out_route_enable
    localparam int RB_CMP_SYNC = 4;     // comparator_sync_route_enable
    localparam int RB_CMP_ASYNC = 5;    // comparator_async_route_enable
    localparam int RB_TWOWIRE_B = 6;    // twowire_b_route_enable
    localparam int RB_NVM_PULLUP = 7;   // nvm_strong_pullup_enable

    ////////////////////////////////////////////////////////////////////////////////
    // Routable functions; the index is the priority rank, zero is highest
    localparam int FN_TX = 0;       // Serial transmit line
    localparam int FN_RX = 1;       // Serial receive line
    localparam int FN_SCK = 2;      // Synchronous serial clock
    localparam int FN_MISO = 3;     // Synchronous serial data in
    localparam int FN_MOSI = 4;     // Synchronous serial data out
    localparam int FN_NSS = 5;      // Synchronous serial select, four-wire mode only
    localparam int FN_SDA_A = 6;    // Two-wire bus A data
    localparam int FN_SCL_A = 7;    // Two-wire bus A clock
    localparam int FN_SDA_B = 8;    // Two-wire bus B data
    localparam int FN_SCL_B = 9;    // Two-wire bus B clock
    localparam int FN_CMP_SYNC = 10;  // Synchronised comparator output
    localparam int FN_CMP_ASYNC = 11; // Asynchronous comparator output
    localparam int FN_SYSCLK = 12;    // Inverted system clock output
    localparam int NUM_FUNC = 13;     // Number of routable functions

    ////////////////////////////////////////////////////////////////////////////////
    // Fixed pins of the asynchronous serial port (port 0 pins 4 and 5)
    localparam int UART_TX_PIN = 4;
    localparam int UART_RX_PIN = 5;

    // Pin count served by default: three ports of eight pins
    localparam int DEFAULT_PINS = 24;
    localparam int MIN_PINS = 8; // Fixed serial pins must exist

endpackage
